// *** common/memctl_defines.svh ***
// Offsets, field positions, command codes and timing counts of the memory controller.
`ifndef MEMCTL_DEFINES_SVH
`define MEMCTL_DEFINES_SVH
`define OFF_REMAP        8'h00
`define OFF_ABORT_STATUS 8'h04
`define OFF_ABORT_ADDR   8'h08
`define OFF_FLASH_MODE   8'h60
`define OFF_FLASH_CMD    8'h64
`define OFF_FLASH_STATUS 8'h68
`define REMAP_BIT        0
`define AS_UNDEF_BIT     0
`define AS_MISAL_BIT     1
`define AS_SIZE_LSB      8
`define AS_TYPE_LSB      10
`define AS_SRC_LSB       16
`define AS_SAVED_LSB     24
`define FM_RDY_IE_BIT    0
`define FM_LOCK_IE_BIT   2
`define FM_FWS_LSB       8
`define FM_MICROSECOND_CYCLE_COUNT_LSB      16
`define FC_CMD_LSB       0
`define FC_PAGE_LSB      8
`define FC_KEY_LSB       24
`define FC_KEY           8'h5A
`define FS_RDY_BIT       0
`define FS_LOCK_ERROR_FLAG_BIT     2
`define FS_PROGRAMMING_ERROR_FLAG_BIT     3
`define FS_NV_LSB        8
`define FS_LOCK_LSB      16
`define CMD_WP           8'h01
`define CMD_SLB          8'h02
`define CMD_WPL          8'h03
`define CMD_CLB          8'h04
`define CMD_EA           8'h08
`define CMD_CMD_SET_NV_BIT         8'h0B
`define CMD_CMD_CLEAR_NV_BIT         8'h0D
`define CMD_SSB          8'h0F
`define CMD_NONE         8'h00
`define CMD_TIME_US      4'h4
`define NV_BITS          3
`define PAGES            4
`define PLANE_WORDS      256
`define PAGE_WORDS       64
`define ERASED_WORD      32'hFFFFFFFF
`endif

// *** common/memctl_types_pkg.sv ***
// Types shared by the memory controller and its bench.
package memctl_types_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } acc_size_e;
    typedef enum logic [1:0] {
        KIND_READ  = 2'h0,
        KIND_WRITE = 2'h1,
        KIND_FETCH = 2'h2
    } acc_kind_e;
    typedef enum logic [1:0] {
        MST_CPU = 2'h0,
        MST_DMA = 2'h1,
        MST_ETH = 2'h2
    } acc_master_e;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'h0,
        ACC_WAIT = 2'h1
    } acc_state_e;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] wdata;
        acc_size_e   size;
        acc_kind_e   kind;
        acc_master_e master;
    } acc_req_s;
    typedef struct packed {
        logic        done;
        logic        abort;
        logic [31:0] rdata;
    } acc_rsp_s;
endpackage

// *** core/memctl_abort_flash_cmd.sv ***
// Memory controller: remap, abort status, flash read timing, latch buffer and commands.
`timescale 1ns/1ps
`include "memctl_defines.svh"
module memctl_abort_flash_cmd (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    input  wire memctl_types_pkg::acc_req_s acc_req,
    output memctl_types_pkg::acc_rsp_s      acc_rsp,
    output logic                            remap_active,
    output logic                            flash_irq
);
    import memctl_types_pkg::*;
    logic [31:0] plane [`PLANE_WORDS];
    logic [31:0] latch [`PAGE_WORDS];
    acc_state_e  st_reg, st_next;
    acc_req_s    req_reg, req_next;
    acc_rsp_s    rsp_reg, rsp_next;
    logic [1:0]  wait_reg, wait_next;
    logic [7:0]  buf_reg, buf_next, pf_reg, pf_next;
    logic        buf_ok_reg, buf_ok_next, pf_ok_reg, pf_ok_next;
    logic        remap_reg, remap_next;
    logic        undef_reg, undef_next, mis_reg, mis_next, fresh_reg, fresh_next;
    logic [1:0]  asz_reg, asz_next, atyp_reg, atyp_next;
    logic [2:0]  src_reg, src_next, saved_reg, saved_next;
    logic [31:0] aadr_reg, aadr_next;
    logic [1:0]  fws_reg, fws_next;
    logic [7:0]  microsecond_cycle_count_reg, microsecond_cycle_count_next, pre_reg, pre_next;
    logic        ie_rdy_reg, ie_rdy_next, ie_lock_reg, ie_lock_next;
    logic        flash_ready_flag_reg, flash_ready_flag_next, programming_error_flag_reg, programming_error_flag_next, lock_error_flag_reg, lock_error_flag_next;
    logic [3:0]  lock_reg, lock_next, left_reg, left_next;
    logic [2:0]  nv_reg, nv_next;
    logic [7:0]  cmd_reg, cmd_next;
    logic [9:0]  cpage_reg, cpage_next;
    logic        pready_reg, pready_next, slverr_reg, slverr_next, irq_reg, irq_next;
    logic [31:0] prdata_reg, prdata_next;
    acc_req_s    cur;
    logic        wr_acc, rd_acc, fin, undef, misal, is_flash, hit_a, hit_b;
    logic        commit, erase, latch_we;
    logic [1:0]  ncyc;
    logic [7:0]  widx, key, code;
    logic [2:0]  src_hot;
    logic [1:0]  page;
    always_comb begin
        wr_acc = psel & penable & pready_reg & pwrite;
        rd_acc = psel & penable & pready_reg & ~pwrite;
        cur    = (st_reg == ACC_IDLE) ? acc_req : req_reg;
        widx   = cur.addr[9:2];
        undef  = cur.addr[31:22] != 10'h000;
        // Instruction fetches are never checked for alignment.
        misal  = (cur.kind != KIND_FETCH) &&
                 (((cur.size == SZ_WORD) && (cur.addr[1:0] != 2'h0)) ||
                  ((cur.size == SZ_HALF) && cur.addr[0]));
        is_flash = (cur.addr[21:20] == 2'h1) || ((cur.addr[21:20] == 2'h0) && ~remap_reg);
        hit_a  = buf_ok_reg && (buf_reg == widx);
        hit_b  = pf_ok_reg && (pf_reg == widx);
        src_hot = 3'h0;
        case (cur.master)
            MST_ETH: src_hot = 3'h1;
            MST_DMA: src_hot = 3'h2;
            default: src_hot = 3'h4;
        endcase
        // Cycles minus one that the access occupies.
        if (undef || misal || !is_flash) begin
            ncyc = 2'h0;
        end else if (cur.kind == KIND_WRITE) begin
            ncyc = (fws_reg == 2'h3) ? 2'h2 : fws_reg;
        end else if ((cur.kind == KIND_FETCH) && (hit_a || (hit_b && (fws_reg <= 2'h1)))) begin
            ncyc = 2'h0;
        end else begin
            // A prefetch hides one wait state but not two or more, so those alternate.
            ncyc = (fws_reg <= 2'h1) ? fws_reg : fws_reg - 2'h1;
        end
        fin = ((st_reg == ACC_IDLE) && acc_req.valid && (ncyc == 2'h0)) ||
              ((st_reg == ACC_WAIT) && (wait_reg == 2'h0));
        st_next  = st_reg;
        req_next = req_reg;
        wait_next = wait_reg;
        rsp_next = '0;
        buf_next = buf_reg;
        buf_ok_next = buf_ok_reg;
        pf_next  = pf_reg;
        pf_ok_next = pf_ok_reg;
        latch_we = 1'b0;
        if ((st_reg == ACC_IDLE) && acc_req.valid && !fin) begin
            st_next  = ACC_WAIT;
            req_next = acc_req;
            wait_next = ncyc - 2'h1;
        end else if (st_reg == ACC_WAIT) begin
            wait_next = wait_reg - 2'h1;
            if (fin) begin
                st_next = ACC_IDLE;
            end
        end
        if (fin) begin
            rsp_next.done  = 1'b1;
            rsp_next.abort = undef || misal;
            if (!(undef || misal) && is_flash) begin
                if (cur.kind == KIND_WRITE) begin
                    latch_we = 1'b1;
                end else begin
                    rsp_next.rdata = plane[widx];
                end
                if (cur.kind == KIND_FETCH) begin
                    buf_next = widx;
                    buf_ok_next = 1'b1;
                    pf_next = widx + 8'h01;
                    pf_ok_next = 1'b1;
                end
            end
        end
        remap_next = remap_reg;
        if (wr_acc && (paddr[7:0] == `OFF_REMAP) && pwdata[`REMAP_BIT]) begin
            remap_next = ~remap_reg;
        end
        undef_next = undef_reg;
        mis_next   = mis_reg;
        asz_next   = asz_reg;
        atyp_next  = atyp_reg;
        src_next   = src_reg;
        aadr_next  = aadr_reg;
        fresh_next = fresh_reg;
        saved_next = saved_reg;
        if (rd_acc && (paddr[7:0] == `OFF_ABORT_STATUS)) begin
            saved_next = 3'h0;
            fresh_next = 1'b0;
        end
        if (fin && (undef || misal)) begin
            undef_next = undef;
            mis_next   = misal;
            asz_next   = cur.size;
            atyp_next  = cur.kind;
            src_next   = src_hot;
            aadr_next  = cur.addr;
            fresh_next = 1'b1;
            // A master displaced from still-unread source bits is remembered; set beats clear.
            saved_next = saved_next | (fresh_reg ? src_reg : 3'h0);
            saved_next = saved_next & ~src_hot;
            saved_next = saved_next | (fresh_reg ? (src_reg & src_hot) : 3'h0);
        end
        fws_next = fws_reg;
        microsecond_cycle_count_next = microsecond_cycle_count_reg;
        ie_rdy_next = ie_rdy_reg;
        ie_lock_next = ie_lock_reg;
        if (wr_acc && (paddr[7:0] == `OFF_FLASH_MODE)) begin
            fws_next = pwdata[`FM_FWS_LSB +: 2];
            microsecond_cycle_count_next = pwdata[`FM_MICROSECOND_CYCLE_COUNT_LSB +: 8];
            ie_rdy_next = pwdata[`FM_RDY_IE_BIT];
            ie_lock_next = pwdata[`FM_LOCK_IE_BIT];
        end
        flash_ready_flag_next = flash_ready_flag_reg;
        programming_error_flag_next = programming_error_flag_reg;
        lock_error_flag_next = lock_error_flag_reg;
        lock_next = lock_reg;
        nv_next = nv_reg;
        cmd_next = cmd_reg;
        cpage_next = cpage_reg;
        left_next = left_reg;
        pre_next = pre_reg;
        commit = 1'b0;
        erase = 1'b0;
        key  = pwdata[`FC_KEY_LSB +: 8];
        code = pwdata[`FC_CMD_LSB +: 8];
        page = cpage_reg[1:0];
        if (rd_acc && (paddr[7:0] == `OFF_FLASH_STATUS)) begin
            programming_error_flag_next = 1'b0;
            lock_error_flag_next = 1'b0;
        end
        if (!flash_ready_flag_reg) begin
            if (pre_reg == microsecond_cycle_count_reg) begin
                pre_next = 8'h00;
                if (left_reg != 4'h0) begin
                    left_next = left_reg - 4'h1;
                end
            end else begin
                pre_next = pre_reg + 8'h01;
            end
            if (left_reg == 4'h0) begin
                flash_ready_flag_next = 1'b1;
                case (cmd_reg)
                    `CMD_WP:   commit = 1'b1;
                    `CMD_WPL: begin
                        commit = 1'b1;
                        lock_next[page] = 1'b1;
                    end
                    `CMD_SLB:  lock_next[page] = 1'b1;
                    `CMD_CLB:  lock_next[page] = 1'b0;
                    `CMD_EA:   erase = 1'b1;
                    `CMD_CMD_SET_NV_BIT: begin
                        if (cpage_reg < 10'(`NV_BITS)) begin
                            nv_next[cpage_reg[1:0]] = 1'b1;
                        end
                    end
                    `CMD_CMD_CLEAR_NV_BIT: begin
                        if (cpage_reg < 10'(`NV_BITS)) begin
                            nv_next[cpage_reg[1:0]] = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end else if (wr_acc && (paddr[7:0] == `OFF_FLASH_CMD)) begin
            flash_ready_flag_next = 1'b0;
            pre_next = 8'h00;
            left_next = `CMD_TIME_US;
            cpage_next = pwdata[`FC_PAGE_LSB +: 10];
            cmd_next = code;
            case (code)
                `CMD_WP, `CMD_SLB, `CMD_WPL, `CMD_CLB, `CMD_EA,
                `CMD_CMD_SET_NV_BIT, `CMD_CMD_CLEAR_NV_BIT, `CMD_SSB: ;
                default: cmd_next = `CMD_NONE;
            endcase
            if ((key != `FC_KEY) || (cmd_next == `CMD_NONE)) begin
                cmd_next = `CMD_NONE;
                programming_error_flag_next = 1'b1;
            end else if ((((code == `CMD_WP) || (code == `CMD_WPL)) &&
                          lock_reg[cpage_next[1:0]]) ||
                         ((code == `CMD_EA) && (lock_reg != 4'h0))) begin
                cmd_next = `CMD_NONE;
                lock_error_flag_next = 1'b1;
            end
            if (cmd_next == `CMD_NONE) begin
                left_next = 4'h0;
            end
        end
        if (commit || erase) begin
            buf_ok_next = 1'b0;
            pf_ok_next = 1'b0;
        end
        irq_next = (flash_ready_flag_reg & ie_rdy_reg) | (lock_error_flag_reg & ie_lock_reg);
        pready_next = psel & ~penable;
        slverr_next = 1'b0;
        prdata_next = 32'h00000000;
        if (psel & ~penable) begin
            case (paddr[7:0])
                `OFF_REMAP: ;
                `OFF_ABORT_STATUS: begin
                    prdata_next[`AS_UNDEF_BIT] = undef_reg;
                    prdata_next[`AS_MISAL_BIT] = mis_reg;
                    prdata_next[`AS_SIZE_LSB +: 2] = asz_reg;
                    prdata_next[`AS_TYPE_LSB +: 2] = atyp_reg;
                    prdata_next[`AS_SRC_LSB +: 3] = src_reg;
                    prdata_next[`AS_SAVED_LSB +: 3] = saved_reg;
                end
                `OFF_ABORT_ADDR: prdata_next = aadr_reg;
                `OFF_FLASH_MODE: begin
                    prdata_next[`FM_RDY_IE_BIT] = ie_rdy_reg;
                    prdata_next[`FM_LOCK_IE_BIT] = ie_lock_reg;
                    prdata_next[`FM_FWS_LSB +: 2] = fws_reg;
                    prdata_next[`FM_MICROSECOND_CYCLE_COUNT_LSB +: 8] = microsecond_cycle_count_reg;
                end
                `OFF_FLASH_CMD: ;
                `OFF_FLASH_STATUS: begin
                    prdata_next[`FS_RDY_BIT] = flash_ready_flag_reg;
                    prdata_next[`FS_LOCK_ERROR_FLAG_BIT] = lock_error_flag_reg;
                    prdata_next[`FS_PROGRAMMING_ERROR_FLAG_BIT] = programming_error_flag_reg;
                    prdata_next[`FS_NV_LSB +: 3] = nv_reg;
                    prdata_next[`FS_LOCK_LSB +: 4] = lock_reg;
                end
                default: slverr_next = 1'b1;
            endcase
            if ((paddr[31:8] != 24'h000000) || (paddr[1:0] != 2'h0)) begin
                slverr_next = 1'b1;
                prdata_next = 32'h00000000;
            end
        end
    end
    // Storage arrays carry no reset: the plane keeps its contents like real flash.
    always_ff @(posedge pclk) begin
        if (latch_we) begin
            latch[cur.addr[7:2]] <= cur.wdata;
        end
        for (int i = 0; i < `PLANE_WORDS; i++) begin
            if (erase) begin
                plane[i] <= `ERASED_WORD;
            end else if (commit && (i / `PAGE_WORDS == int'(page))) begin
                plane[i] <= latch[i % `PAGE_WORDS];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ACC_IDLE;
            req_reg <= '0;
            rsp_reg <= '0;
            wait_reg <= 2'h0;
            buf_reg <= 8'h00;
            buf_ok_reg <= 1'b0;
            pf_reg <= 8'h00;
            pf_ok_reg <= 1'b0;
            remap_reg <= 1'b0;
            undef_reg <= 1'b0;
            mis_reg <= 1'b0;
            asz_reg <= 2'h0;
            atyp_reg <= 2'h0;
            src_reg <= 3'h0;
            saved_reg <= 3'h0;
            fresh_reg <= 1'b0;
            aadr_reg <= 32'h00000000;
            fws_reg <= 2'h0;
            microsecond_cycle_count_reg <= 8'h00;
            ie_rdy_reg <= 1'b0;
            ie_lock_reg <= 1'b0;
            flash_ready_flag_reg <= 1'b1;
            programming_error_flag_reg <= 1'b0;
            lock_error_flag_reg <= 1'b0;
            lock_reg <= 4'h0;
            nv_reg <= 3'h0;
            cmd_reg <= `CMD_NONE;
            cpage_reg <= 10'h000;
            left_reg <= 4'h0;
            pre_reg <= 8'h00;
            pready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            irq_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            req_reg <= req_next;
            rsp_reg <= rsp_next;
            wait_reg <= wait_next;
            buf_reg <= buf_next;
            buf_ok_reg <= buf_ok_next;
            pf_reg <= pf_next;
            pf_ok_reg <= pf_ok_next;
            remap_reg <= remap_next;
            undef_reg <= undef_next;
            mis_reg <= mis_next;
            asz_reg <= asz_next;
            atyp_reg <= atyp_next;
            src_reg <= src_next;
            saved_reg <= saved_next;
            fresh_reg <= fresh_next;
            aadr_reg <= aadr_next;
            fws_reg <= fws_next;
            microsecond_cycle_count_reg <= microsecond_cycle_count_next;
            ie_rdy_reg <= ie_rdy_next;
            ie_lock_reg <= ie_lock_next;
            flash_ready_flag_reg <= flash_ready_flag_next;
            programming_error_flag_reg <= programming_error_flag_next;
            lock_error_flag_reg <= lock_error_flag_next;
            lock_reg <= lock_next;
            nv_reg <= nv_next;
            cmd_reg <= cmd_next;
            cpage_reg <= cpage_next;
            left_reg <= left_next;
            pre_reg <= pre_next;
            pready_reg <= pready_next;
            slverr_reg <= slverr_next;
            prdata_reg <= prdata_next;
            irq_reg <= irq_next;
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = slverr_reg;
    assign acc_rsp = rsp_reg;
    assign remap_active = remap_reg;
    assign flash_irq = irq_reg;
endmodule

// *** test/memctl_abort_flash_cmd_monitor.sv ***
// Port-level checker for the memory controller, bound to its top module.
`timescale 1ns/1ps
module memctl_checker
    import memctl_types_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [31:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       pready,
    input wire memctl_types_pkg::acc_req_s acc_req,
    input wire memctl_types_pkg::acc_rsp_s acc_rsp,
    input wire logic                       remap_active
);
    logic       busy_reg;
    logic       busy_next;
    logic       start;
    logic       flash_word;
    logic [1:0] fws_reg;
    logic [1:0] fws_next;
    // A request raised in the done cycle is taken, so done frees the port.
    assign start = acc_req.valid && (!busy_reg || acc_rsp.done);
    assign flash_word = acc_req.addr[31:20] == 12'h001 && acc_req.addr[1:0] == 2'h0
                        && acc_req.size == SZ_WORD;
    always_comb begin
        busy_next = start || (busy_reg && !acc_rsp.done);
        fws_next = fws_reg;
        if (psel && penable && pready && pwrite && paddr == 32'h00000060) begin
            fws_next = pwdata[9:8];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'h0;
            fws_reg <= 2'h0;
        end else begin
            busy_reg <= busy_next;
            fws_reg <= fws_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_remap_wr;
        psel && penable && pready && pwrite && paddr == 32'h00000000;
    endsequence
    sequence s_abort_now;
        acc_rsp.done && acc_rsp.abort;
    endsequence
    property p_remap_toggle;
        s_remap_wr ##0 pwdata[0] |=> remap_active != $past(remap_active);
    endproperty
    property p_remap_hold;
        s_remap_wr ##0 !pwdata[0] |=> $stable(remap_active);
    endproperty
    property p_word_misal;
        start && acc_req.size == SZ_WORD && acc_req.addr[1:0] != 2'h0
        && acc_req.kind != KIND_FETCH |=> s_abort_now;
    endproperty
    property p_half_misal;
        start && acc_req.size == SZ_HALF && acc_req.addr[0]
        && acc_req.kind != KIND_FETCH |=> s_abort_now;
    endproperty
    property p_undef_abort;
        start && acc_req.addr[31:22] != 10'h000 |=> s_abort_now;
    endproperty
    property p_fws0;
        start && fws_reg == 2'h0 |=> acc_rsp.done;
    endproperty
    property p_write_fws1;
        start && fws_reg == 2'h1 && flash_word && acc_req.kind == KIND_WRITE
        |=> !acc_rsp.done ##1 acc_rsp.done;
    endproperty
    property p_read_fws3;
        start && fws_reg == 2'h3 && flash_word && acc_req.kind == KIND_READ
        |=> !acc_rsp.done [*2] ##1 acc_rsp.done;
    endproperty
    property p_apb_answer;
        psel && !penable |=> pready;
    endproperty
    a_remap_toggle: assert property (p_remap_toggle) else $error("remap did not toggle");
    a_remap_hold: assert property (p_remap_hold) else $error("remap changed on zero");
    a_word_misal: assert property (p_word_misal) else $error("word not aborted");
    a_half_misal: assert property (p_half_misal) else $error("half not aborted");
    a_undef_abort: assert property (p_undef_abort) else $error("undefined not aborted");
    a_fws0: assert property (p_fws0) else $error("access not single cycle");
    a_write_fws1: assert property (p_write_fws1) else $error("write time wrong");
    a_read_fws3: assert property (p_read_fws3) else $error("data read time wrong");
    a_apb_answer: assert property (p_apb_answer) else $error("no ready in access");
endmodule
bind memctl_abort_flash_cmd memctl_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .acc_req(acc_req), .acc_rsp(acc_rsp), .remap_active(remap_active));

// *** test/memctl_master_model.sv ***
// Behavioural model of the bus masters that reach the access port.
`timescale 1ns/1ps
module memctl_master_model
    import memctl_types_pkg::*;
(
    input  wire logic                       pclk,
    output memctl_types_pkg::acc_req_s      acc_req,
    input  wire memctl_types_pkg::acc_rsp_s acc_rsp
);
    initial acc_req = '0;
    task automatic access(input logic [31:0] a, input acc_size_e s, input acc_kind_e k,
                          input acc_master_e m, output int n, output acc_rsp_s r);
        @(posedge pclk);
        acc_req <= '{1'h1, a, ~a, s, k, m};
        n = 0;
        do begin
            @(posedge pclk);
            // Released address and data show the inverse so stale values cannot pass.
            acc_req <= '{1'h0, ~a, a, s, k, m};
            #1;
            n++;
        end while (acc_rsp.done !== 1'h1 && n < 20);
        r = acc_rsp;
    endtask
endmodule

// *** test/memctl_abort_flash_cmd_tb.sv ***
// Self-checking bench for the memory controller.
`timescale 1ns/1ps
module memctl_abort_flash_cmd_tb;
    import memctl_types_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        remap_active, flash_irq;
    logic [31:0] paddr, pwdata, prdata, r;
    acc_req_s    acc_req;
    acc_rsp_s    acc_rsp, rsp;
    int          n_fail, n_tests, cyc, m, nx, k;
    logic [31:0] cw[12] = '{32'h5A000102, 32'h5A000101, 32'h5A000104, 32'h5A000003,
        32'h5A000008, 32'h5A000004, 32'h5A000008, 32'h5A00010B, 32'h5A00010D,
        32'h5A00000F, 32'h33000001, 32'h5A000007};
    logic [31:0] ex[12] = '{32'h00020001, 32'h00020005, 32'h00000001, 32'h00010001,
        32'h00010005, 32'h00000001, 32'h00000001, 32'h00000201, 32'h00000001,
        32'h00000001, 32'h00000009, 32'h00000009};
    memctl_abort_flash_cmd uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc_req(acc_req),
        .acc_rsp(acc_rsp), .remap_active(remap_active), .flash_irq(flash_irq));
    memctl_master_model mst (.pclk(pclk), .acc_req(acc_req), .acc_rsp(acc_rsp));
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (i >= 20) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, r);
    endtask
    task automatic ac(input logic [31:0] a, input acc_size_e s, input acc_kind_e kd,
                      input acc_master_e ms);
        mst.access(a, s, kd, ms, cyc, rsp);
        chk("access done", 32'h1, {31'h0, rsp.done});
        if (rsp.done !== 1'h1) conclude();
    endtask
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rdc("abort status", 32'h4, 32'h0);
        rdc("abort address", 32'h8, 32'h0);
        apb(1'h0, 32'hC, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("remap", 32'h0, {31'h0, remap_active});
        foreach (cw[i]) begin
            if (i < 3) begin
                apb(1'h1, 32'h0, (i == 2) ? 32'h2 : 32'h1);
                @(posedge pclk);
                chk("remap", {31'h0, i == 0}, {31'h0, remap_active});
            end
        end
        ac(32'h20000000, SZ_WORD, KIND_FETCH, MST_CPU);
        rdc("abort status", 32'h4, 32'h00040A01);
        rdc("abort address", 32'h8, 32'h20000000);
        ac(32'h00100002, SZ_WORD, KIND_WRITE, MST_DMA);
        ac(32'h10000000, SZ_HALF, KIND_READ, MST_ETH);
        rdc("abort status", 32'h4, 32'h02010101);
        rdc("abort status", 32'h4, 32'h00010101);
        ac(32'h00100001, SZ_HALF, KIND_READ, MST_CPU);
        rdc("abort status", 32'h4, 32'h00040102);
        ac(32'h00100002, SZ_WORD, KIND_FETCH, MST_CPU);
        chk("fetch abort", 32'h0, {31'h0, rsp.abort});
        for (int f = 0; f < 4; f++) begin
            apb(1'h1, 32'h60, {8'h00, 8'h01, 6'h00, f[1:0], 8'h01});
            m = (f < 2) ? f + 1 : f;
            nx = (f <= 1) ? 1 : f;
            for (int i = 0; i < 4; i++) begin
                ac(32'h00100000 + 32'(f * 256 + i * 2), SZ_HALF, KIND_FETCH, MST_CPU);
                chk("fetch cycles", 32'(i[0] ? 1 : (i == 0 ? m : nx)), 32'(cyc));
            end
            repeat (2) begin
                ac(32'h00100020 + 32'(f * 256), SZ_WORD, KIND_READ, MST_CPU);
                chk("read cycles", 32'(m), 32'(cyc));
            end
            ac(32'h00100040 + 32'(f * 256), SZ_WORD, KIND_WRITE, MST_CPU);
            chk("write cycles", 32'(f == 3 ? 3 : f + 1), 32'(cyc));
        end
        foreach (cw[i]) begin
            apb(1'h1, 32'h64, cw[i]);
            if (ex[i][3:2] == 2'h0) begin
                apb(1'h0, 32'h68, 32'h0);
                chk("ready after command", 32'h0, {31'h0, r[0]});
            end
            // Let the late interrupt line follow the dropped ready first.
            repeat (3) @(posedge pclk);
            k = 0;
            while (flash_irq !== 1'h1 && k < 200) begin
                @(posedge pclk);
                k++;
            end
            chk("ready interrupt", 32'h1, {31'h0, flash_irq});
            if (flash_irq !== 1'h1) conclude();
            apb(1'h0, 32'h68, 32'h0);
            chk("flash status", ex[i], r & 32'h000F070D);
            apb(1'h0, 32'h68, 32'h0);
            chk("status reread", ex[i] & 32'hFFFFFFF3, r & 32'h000F070D);
        end
        ac(32'h00100001, SZ_BYTE, KIND_READ, MST_DMA);
        chk("flash data", 32'hFFFFFFFF, rsp.rdata);
        ac(32'h001C0402, SZ_HALF, KIND_READ, MST_ETH);
        chk("wrapped flash data", 32'hFFFFFFFF, rsp.rdata);
        conclude();
    end
endmodule
